//--- include/mmio_pkg.sv
// constants for the misc i/o instruction executor
// assumes one instruction word is offered per machine cycle
package mmio_pkg;
    // widths
    localparam int INSTR_W = 10;
    localparam int NIB_W = 4;
    localparam int FILE_W = 2;
    localparam int PC_W = 14;
    localparam int PORT_N = 5;
    // opcodes
    localparam logic [9:0] OPC_NOP = 10'h000;
    localparam logic [9:0] OPC_OR = 10'h019;
    localparam logic [9:0] OPC_LOAD_FILE = 10'h048;
    localparam logic [9:0] OPC_LOAD_FILE_MASK = 10'h3FC;
    localparam logic [9:0] OPC_PORT_BASE = 10'h220;
    localparam logic [9:0] OPC_PORT_MASK = 10'h3F8;
    localparam logic [2:0] PORT_LAST = 3'h4;
    // field positions
    localparam int FILE_LSB = 0;
    localparam int PORT_SEL_LSB = 0;
    localparam int PORT_SEL_W = 3;
    // reset values and program counter step
    localparam logic [3:0] ACC_RST = 4'h0;
    localparam logic [1:0] FILE_RST = 2'h0;
    localparam logic [13:0] PC_RST = 14'h0000;
    localparam logic [3:0] PORT_RST = 4'h0;
    localparam logic CARRY_RST = 1'h0;
    localparam logic [13:0] PC_STEP = 14'h0001;
endpackage

//--- sim/mmio_exec_tb.sv
// self-checking bench for the misc i/o instruction executor
// assumes mmio_pkg is compiled first; drives the executor ports directly
`timescale 1ns/1ps
module mmio_exec_tb;
    logic core_clk_i;
    logic reset_n_i = 1'h0;
    logic instr_valid_i = 1'h0;
    logic [9:0] instr_i = 10'h3FF;
    logic [3:0] ram_data_i = 4'h0;
    logic [3:0] acc_o;
    logic [1:0] load_file_select_o;
    logic [13:0] program_counter_o;
    logic carry_flag_o;
    logic done_o;
    logic foreign_o;
    logic [3:0] port_zero_o, port_one_o, port_two_o, port_three_o, port_four_o;
    logic [19:0] ports_w;
    logic [26:0] state_w;
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;
    assign ports_w = {port_four_o, port_three_o, port_two_o, port_one_o, port_zero_o};
    assign state_w = {acc_o, load_file_select_o, carry_flag_o, ports_w};
    mmio_exec mmio_exec_inst (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
        .instr_valid_i(instr_valid_i), .instr_i(instr_i), .ram_data_i(ram_data_i),
        .acc_o(acc_o), .load_file_select_o(load_file_select_o),
        .program_counter_o(program_counter_o), .carry_flag_o(carry_flag_o),
        .done_o(done_o), .foreign_o(foreign_o), .port_zero_o(port_zero_o),
        .port_one_o(port_one_o), .port_two_o(port_two_o), .port_three_o(port_three_o),
        .port_four_o(port_four_o));
    // ----------------------------------------
    // clock and hang guard
    // ----------------------------------------
    initial
    begin
        core_clk_i = 1'h0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            failures++;
            finish_test();
        end
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic issue(input logic [9:0] w, input logic [3:0] d);
        instr_valid_i = 1'h1;
        instr_i = w;
        ram_data_i = d;
        @(posedge core_clk_i);
        #1;
    endtask
    task automatic do_reset();
        reset_n_i = 1'h0;
        instr_valid_i = 1'h0;
        repeat (5) @(posedge core_clk_i);
        #1;
        reset_n_i = 1'h1;
    endtask
    task automatic finish_test();
        $display("failures %0d samples_checked %0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_or();
        logic [13:0] pc;
        pc = program_counter_o;
        issue(mmio_pkg::OPC_OR, 4'h5);
        check("or acc", 32'h5, 32'(acc_o));
        check("or pc", 32'(pc + 14'h0001), 32'(program_counter_o));
        check("or done", 32'h1, 32'(done_o));
        issue(mmio_pkg::OPC_OR, 4'h3);
        check("or acc 2", 32'h7, 32'(acc_o));
        check("or carry", 32'h0, 32'(carry_flag_o));
        check("or pc 2", 32'(pc + 14'h0002), 32'(program_counter_o));
    endtask
    task automatic test_load_file();
        for (int z = 3; z >= 0; z--)
        begin
            issue(mmio_pkg::OPC_LOAD_FILE | 10'(z), 4'hF);
            check("file sel", 32'(z), 32'(load_file_select_o));
            check("file acc", 32'h7, 32'(acc_o));
            check("file carry", 32'h0, 32'(carry_flag_o));
        end
    endtask
    task automatic test_nop_foreign();
        logic [26:0] st;
        logic [13:0] pc;
        st = state_w;
        pc = program_counter_o;
        issue(mmio_pkg::OPC_NOP, 4'hF);
        check("nop state", 32'(st), 32'(state_w));
        check("nop pc", 32'(pc + 14'h0001), 32'(program_counter_o));
        check("nop flags", 32'h2, 32'({done_o, foreign_o}));
        for (int w = 5; w < 8; w++)
        begin
            issue(mmio_pkg::OPC_PORT_BASE | 10'(w), 4'hF);
            check("foreign state", 32'(st), 32'(state_w));
            check("foreign pc", 32'(pc + 14'h0001), 32'(program_counter_o));
            check("foreign flags", 32'h1, 32'({done_o, foreign_o}));
        end
        instr_valid_i = 1'h0;
        @(posedge core_clk_i);
        #1;
        check("idle flags", 32'h0, 32'({done_o, foreign_o}));
    endtask
    task automatic test_ports();
        logic [19:0] exp;
        logic [3:0] acc;
        do_reset();
        check("reset state", 32'h0, 32'(state_w));
        check("reset pc", 32'h0, 32'(program_counter_o));
        exp = 20'h00000;
        acc = 4'h0;
        for (int k = 0; k < 5; k++)
        begin
            if (k < 4)
                acc = acc | 4'(1 << k);
            issue(mmio_pkg::OPC_OR, 4'(1 << k) & 4'hF);
            issue(mmio_pkg::OPC_PORT_BASE | 10'(k), 4'h0);
            exp[k * 4 +: 4] = acc;
            check("port latches", 32'(exp), 32'(ports_w));
            check("port acc", 32'(acc), 32'(acc_o));
            check("port carry", 32'h0, 32'(carry_flag_o));
            check("port done", 32'h1, 32'(done_o));
        end
        check("port pc", 32'hA, 32'(program_counter_o));
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        do_reset();
        test_or();
        test_load_file();
        test_nop_foreign();
        test_ports();
        finish_test();
    end
endmodule

//--- verilog/mmio_exec.sv
// executor for load-file, no-op, port output and or-with-memory
// assumes the core offers a word with instr_valid_i once per machine cycle
// and presents the nibble addressed by the data pointer on ram_data_i
// How it works
// RULE1: the load-file word copies its two-bit immediate into the file register in one cycle.
// RULE2: the all-zeros word advances the program counter and raises done, leaving accumulator, file, carry and ports unchanged.
// RULE3: the port-zero word copies the accumulator into the port-zero latch in one cycle.
// RULE4: the port-one word copies the accumulator into the port-one latch in one cycle.
// RULE5: the port-two word copies the accumulator into the port-two latch in one cycle.
// RULE6: the port-three word copies the accumulator into the port-three latch in one cycle.
// RULE7: the port-four word copies the accumulator into the port-four latch in one cycle.
// RULE8: the or word ors the memory nibble into the accumulator, carry left alone.
// RULE9: each of these words advances the program counter by one.
`timescale 1ns/1ps
module mmio_exec
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // instruction stream
    input wire logic instr_valid_i,
    input wire logic [9:0] instr_i,
    // memory nibble at data pointer
    input wire logic [3:0] ram_data_i,
    // core state
    output logic [3:0] acc_o,
    output logic [1:0] load_file_select_o,
    output logic [13:0] program_counter_o,
    output logic carry_flag_o,
    // execution status
    output logic done_o,
    output logic foreign_o,
    // port latches
    output logic [3:0] port_zero_o,
    output logic [3:0] port_one_o,
    output logic [3:0] port_two_o,
    output logic [3:0] port_three_o,
    output logic [3:0] port_four_o
);
    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    logic is_nop;
    logic is_or;
    logic is_load_file;
    logic is_port;
    logic [2:0] port_sel;
    logic [4:0] port_we;
    logic ours;
    logic [3:0] acc_q;
    logic [1:0] file_q;
    logic [13:0] pc_q;
    logic carry_q;
    logic done_q;
    logic foreign_q;
    logic [4:0][3:0] port_q;

    assign port_sel = instr_i[mmio_pkg::PORT_SEL_LSB +: mmio_pkg::PORT_SEL_W];
    assign is_nop = instr_i == mmio_pkg::OPC_NOP;
    assign is_or = instr_i == mmio_pkg::OPC_OR;
    assign is_load_file = (instr_i & mmio_pkg::OPC_LOAD_FILE_MASK) == mmio_pkg::OPC_LOAD_FILE;
    assign is_port = ((instr_i & mmio_pkg::OPC_PORT_MASK) == mmio_pkg::OPC_PORT_BASE)
        && (port_sel <= mmio_pkg::PORT_LAST);
    assign ours = is_nop || is_or || is_load_file || is_port;

    always_comb
    begin
        port_we = 5'h00;
        if (instr_valid_i && is_port)
        begin
            port_we[port_sel] = 1'h1; // see RULE3 RULE4 RULE5 RULE6 RULE7
        end
    end

    // ----------------------------------------------------------------
    // accumulator
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            acc_q <= mmio_pkg::ACC_RST;
        end
        else if (instr_valid_i && is_or)
        begin
            acc_q <= acc_q | ram_data_i; // see RULE8
        end
    end

    // ----------------------------------------------------------------
    // file register
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            file_q <= mmio_pkg::FILE_RST;
        end
        else if (instr_valid_i && is_load_file)
        begin
            file_q <= instr_i[mmio_pkg::FILE_LSB +: mmio_pkg::FILE_W]; // see RULE1
        end
    end

    // ----------------------------------------------------------------
    // program counter
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            pc_q <= mmio_pkg::PC_RST;
        end
        else if (instr_valid_i && ours)
        begin
            pc_q <= pc_q + mmio_pkg::PC_STEP; // see RULE9 RULE2
        end
    end

    // carry is held; none of these words alters it
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            carry_q <= mmio_pkg::CARRY_RST;
        end
        else
        begin
            carry_q <= carry_q;
        end
    end

    // ----------------------------------------------------------------
    // status
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            done_q <= 1'h0;
            foreign_q <= 1'h0;
        end
        else
        begin
            done_q <= instr_valid_i && ours;
            foreign_q <= instr_valid_i && !ours;
        end
    end

    // ----------------------------------------------------------------
    // port latches
    // ----------------------------------------------------------------
    mmio_port_bank u_ports
    (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .wr_en_i(port_we),
        .wr_data_i(acc_q),
        .port_q_o(port_q)
    );

    assign acc_o = acc_q;
    assign load_file_select_o = file_q;
    assign program_counter_o = pc_q;
    assign carry_flag_o = carry_q;
    assign done_o = done_q;
    assign foreign_o = foreign_q;
    assign port_zero_o = port_q[0];
    assign port_one_o = port_q[1];
    assign port_two_o = port_q[2];
    assign port_three_o = port_q[3];
    assign port_four_o = port_q[4];

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    sequence s_issue(logic [9:0] opc);
        instr_valid_i && instr_i == opc;
    endsequence

    sequence s_port_issue(logic [2:0] n);
        instr_valid_i && instr_i == (mmio_pkg::OPC_PORT_BASE | {7'h00, n});
    endsequence

    a_file_load: assert property ( // see RULE1
        instr_valid_i && is_load_file
            |=> file_q == $past(instr_i[mmio_pkg::FILE_LSB +: mmio_pkg::FILE_W])
            && $stable(acc_q))
        else $error("file register not loaded from immediate");
    a_nop_quiet: assert property ( // see RULE2
        s_issue(mmio_pkg::OPC_NOP) |=> $stable(acc_q) && $stable(file_q) && $stable(port_q)
            && pc_q == $past(pc_q) + 14'h0001)
        else $error("no-op changed state");
    a_port0_write: assert property ( // see RULE3
        s_port_issue(3'h0) |=> port_q[0] == $past(acc_q) && $stable(port_q[1]))
        else $error("port zero not written");
    a_port1_write: assert property ( // see RULE4
        s_port_issue(3'h1) |=> port_q[1] == $past(acc_q) && $stable(port_q[0]))
        else $error("port one not written");
    a_port2_write: assert property ( // see RULE5
        s_port_issue(3'h2) |=> port_q[2] == $past(acc_q) && $stable(port_q[3]))
        else $error("port two not written");
    a_port3_write: assert property ( // see RULE6
        s_port_issue(3'h3) |=> port_q[3] == $past(acc_q) && $stable(port_q[4]))
        else $error("port three not written");
    a_port4_write: assert property ( // see RULE7
        s_port_issue(3'h4) |=> port_q[4] == $past(acc_q) && $stable(port_q[2]))
        else $error("port four not written");
    a_or_result: assert property ( // see RULE8
        s_issue(mmio_pkg::OPC_OR) |=> acc_q == ($past(acc_q) | $past(ram_data_i))
            && $stable(carry_q))
        else $error("or result wrong");
    a_pc_advance: assert property ( // see RULE9
        instr_valid_i && ours |=> pc_q == $past(pc_q) + 14'h0001 && done_q)
        else $error("program counter not advanced");
    a_pc_hold: assert property ( // see RULE9
        !(instr_valid_i && ours) |=> $stable(pc_q) && !done_q)
        else $error("program counter moved without instruction");
    // words outside the group raise foreign_q and leave accumulator, file, ports and pc alone
    a_foreign_quiet: assert property ( // no RULE covers words outside the group
        instr_valid_i && !ours |=> foreign_q && $stable(acc_q) && $stable(file_q)
            && $stable(port_q) && $stable(pc_q))
        else $error("foreign word changed state");
endmodule

//--- verilog/mmio_port_bank.sv
// output latches of ports zero to four
// assumes one-hot write strobes from the executor on the same clock
`timescale 1ns/1ps
module mmio_port_bank
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // write side
    input wire logic [4:0] wr_en_i,
    input wire logic [3:0] wr_data_i,
    // latch contents
    output logic [4:0][3:0] port_q_o
);
    for (genvar g = 0; g < mmio_pkg::PORT_N; g++)
    begin : g_port
        always_ff @(posedge core_clk_i or negedge reset_n_i)
        begin
            if (!reset_n_i)
            begin
                port_q_o[g] <= mmio_pkg::PORT_RST;
            end
            else if (wr_en_i[g])
            begin
                port_q_o[g] <= wr_data_i;
            end
        end
    end
endmodule
